// ===== crcs_pkg.sv
// shared constants and types of the config, run control and status bank
`default_nettype none
package crcs_pkg;
  localparam int WR_REG_COUNT = 78;
  localparam int HW_REG_COUNT = 51;
  localparam int FW_REG_COUNT = 27;
  localparam logic [6:0] RUN_CTRL_IDX   = 7'h4d;
  localparam int         RUN_BIT_POS    = 0;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [6:0] CMP_EN_IDX     = 7'h00;
  localparam int         CMP_EN_POS     = 7;
  localparam logic [6:0] NVM_AWAKE_IDX  = 7'h02;
  localparam int         NVM_AWAKE_POS  = 0;
  localparam logic [6:0] RTC_CFG_IDX    = 7'h04;
  localparam int         RTC_EN_POS     = 0;
  localparam int         RTC_SEL_POS    = 1;
  localparam logic [6:0] SRAM_SEL_IDX   = 7'h2b;
  localparam int         SRAM_SEL_POS   = 0;
  localparam logic [6:0] BG_TRIM_IDX    = 7'h30;
  localparam int         SUP_SEL_POS    = 4;
  localparam int RD_BYTE_COUNT = 44;
  localparam int RESULT_COUNT  = 11;
  localparam logic [5:0] STATUS_LOW_ADDR  = 6'h18;
  localparam logic [5:0] STATUS_MID_ADDR  = 6'h19;
  localparam logic [5:0] STATUS_HIGH_ADDR = 6'h1a;
  localparam logic [5:0] RES_HIGH_FIRST   = 6'h1b;
  localparam logic [5:0] RES_HIGH_LAST    = 6'h20;
  localparam logic [5:0] RD_LAST_ADDR     = 6'h2b;
  localparam int         TRIG_BIT_POS     = 14;
  localparam int         BUSY_BIT_POS     = 8;
  localparam logic [6:0] SUPPLY_RAM_ADDR  = 7'h5c;
  localparam int RTC_PRESCALE_BITS = 17;
  localparam int SUPPLY_CONV_TICKS = 17;
  localparam int SUPPLY_SLOW_DIV   = 16;
  localparam int SUPPLY_RES_BITS   = 6;
  typedef enum logic [2:0] {
    CMP_OFF     = 3'b000,
    CMP_RD      = 3'b001,
    CMP_CHK     = 3'b010,
    CMP_RESET   = 3'b011,
    CMP_COPY    = 3'b100,
    CMP_COPY_WR = 3'b101,
    CMP_RESTART = 3'b110
  } crcs_cmp_type;
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } crcs_host_wr_type;
  typedef struct packed {
    logic       en;
    logic [5:0] addr;
    logic [7:0] data;
  } crcs_res_wr_type;
endpackage
`default_nettype wire

// ===== crcs_rtc.sv
// real-time counter: prescaler then gray-coded count
`default_nettype none
module crcs_rtc #(
  parameter int COUNT_BITS = 16,
  parameter int PRE_BITS   = crcs_pkg::RTC_PRESCALE_BITS
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  enable_i,
  input  wire logic                  tick_i,
  output logic      [COUNT_BITS-1:0] gray_o
);
  logic [PRE_BITS-1:0]   pre;
  logic [COUNT_BITS-1:0] bin;
  wire                   wrap = tick_i && (&pre);
  wire [COUNT_BITS-1:0]  next_bin = bin + COUNT_BITS'(1);

  // counts only while enabled; holds its value otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre    <= '0;
      bin    <= '0;
      gray_o <= '0;
    end else if (enable_i && tick_i) begin
      pre <= pre + PRE_BITS'(1);
      if (wrap) begin
        bin    <= next_bin;
        gray_o <= next_bin ^ (next_bin >> 1);
      end
    end
  end

  // gray code never moves more than one bit at a step
  property p_gray_step;
    @(posedge clk_i) disable iff (rst_i)
      (gray_o != $past(gray_o)) |-> $onehot(gray_o ^ $past(gray_o));
  endproperty
  a_gray_step: assert property (p_gray_step) else $error("gray step not one bit");
endmodule
`default_nettype wire

// ===== crcs_supply.sv
// supply voltage conversion timer and result capture
`default_nettype none
module crcs_supply #(
  parameter int TICKS = crcs_pkg::SUPPLY_CONV_TICKS,
  parameter int DIV   = crcs_pkg::SUPPLY_SLOW_DIV,
  parameter int RES_W = crcs_pkg::SUPPLY_RES_BITS
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic             slow_i,
  input  wire logic             olf_tick_i,
  input  wire logic [RES_W-1:0] sample_i,
  output logic                  busy_o,
  output logic                  done_o,
  output logic      [RES_W-1:0] result_o
);
  logic [$clog2(DIV)-1:0]   div;
  logic [$clog2(TICKS)-1:0] cnt;
  // slow mode lets one base tick through every DIV oscillator ticks
  wire base_tick = olf_tick_i && (!slow_i || (&div));
  wire last_tick = base_tick && (cnt == ($clog2(TICKS))'(TICKS - 1));

  // divider runs only during a conversion so both modes start aligned
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      div <= '0;
    end else if (olf_tick_i) begin
      div <= div + ($clog2(DIV))'(1);
    end
  end

  // conversion: TICKS base ticks, then result captured once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      cnt      <= '0;
      result_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        busy_o <= 1'b1;
        cnt    <= '0;
      end else if (busy_o && base_tick) begin
        cnt <= cnt + ($clog2(TICKS))'(1);
        if (last_tick) begin
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          result_o <= sample_i;
        end
      end
    end
  end

  property p_start_busy;
    @(posedge clk_i) disable iff (rst_i)
      (start_i && !busy_o) |=> busy_o ##0 !done_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

  property p_done_idle;
    @(posedge clk_i) disable iff (rst_i)
      done_o |-> !busy_o && $past(busy_o);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("done without conversion");
endmodule
`default_nettype wire

// ===== crcs_top.sv
// configuration, run control and status register bank with its control units
`default_nettype none
module crcs_top #(
  parameter int PM_AW  = 12,
  parameter int RTC_W  = 16
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire crcs_pkg::crcs_host_wr_type host_wr_i,
  input  wire logic                [5:0] host_rd_addr_i,
  output logic                     [7:0] host_rd_data_o,
  input  wire crcs_pkg::crcs_res_wr_type res_wr_i,
  output logic [crcs_pkg::WR_REG_COUNT-1:0][7:0] cfg_o,
  output logic                           frontend_run_o,
  input  wire logic                      dsp_out_we_i,
  input  wire logic               [15:0] dsp_out_i,
  output logic                    [15:0] dsp_in_o,
  output logic                           supply_ram_we_o,
  output logic                     [6:0] supply_ram_addr_o,
  output logic                     [7:0] supply_ram_data_o,
  input  wire logic                      low_freq_oscillator_i,
  input  wire logic                      ext_32k_i,
  input  wire logic                [5:0] supply_sample_i,
  output logic             [RTC_W-1:0] rtc_gray_o,
  input  wire logic                      nvm_access_i,
  output logic                           nvm_awake_o,
  input  wire logic                      dsp_stop_cmd_i,
  input  wire logic                      gpio_wake_i,
  input  wire logic                      run_end_i,
  output logic                           dsp_clk_en_o,
  input  wire logic                      dsp_idle_i,
  input  wire logic                      ring_osc_sel_i,
  output logic             [PM_AW-1:0] pm_addr_o,
  input  wire logic                [7:0] pm_sram_data_i,
  input  wire logic                [7:0] pm_otp_data_i,
  output logic                           pm_sram_we_o,
  output logic                     [7:0] pm_sram_wdata_o,
  output logic                           por_o,
  output logic                           dsp_restart_o
);
  ////////////////////////////////////////////////////////////////////////////
  // write register space
  logic [crcs_pkg::WR_REG_COUNT-1:0][7:0] cfg;
  logic [crcs_pkg::RD_BYTE_COUNT-1:0][7:0] rd_ram;

  wire wr_hit = host_wr_i.en &&
                (host_wr_i.addr < 7'(crcs_pkg::WR_REG_COUNT));
  wire run_en = cfg[crcs_pkg::RUN_CTRL_IDX][crcs_pkg::RUN_BIT_POS];
  wire cmp_en = cfg[crcs_pkg::CMP_EN_IDX][crcs_pkg::CMP_EN_POS];
  wire keep_awake = cfg[crcs_pkg::NVM_AWAKE_IDX][crcs_pkg::NVM_AWAKE_POS];
  wire rtc_en  = cfg[crcs_pkg::RTC_CFG_IDX][crcs_pkg::RTC_EN_POS];
  wire rtc_sel = cfg[crcs_pkg::RTC_CFG_IDX][crcs_pkg::RTC_SEL_POS];
  wire sram_sel = cfg[crcs_pkg::SRAM_SEL_IDX][crcs_pkg::SRAM_SEL_POS];
  wire sup_slow = cfg[crcs_pkg::BG_TRIM_IDX][crcs_pkg::SUP_SEL_POS];

  // out-of-range writes are dropped; run byte keeps only its one bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= {crcs_pkg::WR_REG_COUNT{crcs_pkg::CFG_RESET}};
    end else if (wr_hit) begin
      if (host_wr_i.addr == crcs_pkg::RUN_CTRL_IDX) begin
        cfg[host_wr_i.addr] <= {7'h00, host_wr_i.data[0]};
      end else begin
        cfg[host_wr_i.addr] <= host_wr_i.data;
      end
    end
  end

  assign cfg_o          = cfg;
  assign frontend_run_o = run_en;

  ////////////////////////////////////////////////////////////////////////////
  // read space: firmware results plus hard-wired status triple
  wire res_in_status = (res_wr_i.addr >= crcs_pkg::STATUS_LOW_ADDR) &&
                       (res_wr_i.addr <= crcs_pkg::STATUS_HIGH_ADDR);
  wire res_ok = res_wr_i.en && !res_in_status &&
                (res_wr_i.addr <= crcs_pkg::RD_LAST_ADDR);

  // firmware may not overwrite the status bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_ram <= '0;
    end else if (res_ok) begin
      rd_ram[res_wr_i.addr] <= res_wr_i.data;
    end
  end

  logic       supply_busy;
  logic       cmp_active;
  logic       mismatch_seen;
  logic [5:0] supply_result;
  logic       trig;

  wire [7:0] status_low = {3'h0, nvm_awake_o, cmp_active, supply_busy,
                           dsp_clk_en_o, run_en};
  wire [7:0] status_mid = {2'h0, supply_result};
  wire [7:0] status_high = {7'h00, mismatch_seen};
  wire [7:0] rd_sel =
    (host_rd_addr_i == crcs_pkg::STATUS_LOW_ADDR)  ? status_low :
    (host_rd_addr_i == crcs_pkg::STATUS_MID_ADDR)  ? status_mid :
    (host_rd_addr_i == crcs_pkg::STATUS_HIGH_ADDR) ? status_high :
    (host_rd_addr_i <= crcs_pkg::RD_LAST_ADDR) ? rd_ram[host_rd_addr_i] : 8'h00;

  // read data is registered: one cycle after the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_rd_data_o <= 8'h00;
    end else begin
      host_rd_data_o <= rd_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nvm power: awake per access or permanently
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_awake_o <= 1'b0;
    end else begin
      nvm_awake_o <= keep_awake || nvm_access_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // real-time counter with source select on sampled clock levels
  logic src_q;
  logic olf_q;
  wire  rtc_src  = rtc_sel ? low_freq_oscillator_i : ext_32k_i;
  wire  rtc_tick = rtc_src && !src_q;
  wire  olf_tick = low_freq_oscillator_i && !olf_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= 1'b0;
      olf_q <= 1'b0;
    end else begin
      src_q <= rtc_src;
      olf_q <= low_freq_oscillator_i;
    end
  end

  crcs_rtc #(.COUNT_BITS(RTC_W)) u_rtc (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (rtc_en),
    .tick_i   (rtc_tick),
    .gray_o   (rtc_gray_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supply check: trigger bit, busy flag, result to processor RAM
  logic sup_done;
  wire  trig_set = dsp_out_we_i && dsp_out_i[crcs_pkg::TRIG_BIT_POS];
  wire  sup_start = trig && !supply_busy;

  // set wins over the self-clear so a back-to-back trigger survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig <= 1'b0;
    end else if (trig_set) begin
      trig <= 1'b1;
    end else if (sup_start) begin
      trig <= 1'b0;
    end
  end

  crcs_supply u_supply (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (sup_start),
    .slow_i     (sup_slow),
    .olf_tick_i (olf_tick),
    .sample_i   (supply_sample_i),
    .busy_o     (supply_busy),
    .done_o     (sup_done),
    .result_o   (supply_result)
  );

  // busy bit and ram write both come straight from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsp_in_o          <= 16'h0000;
      supply_ram_we_o   <= 1'b0;
      supply_ram_addr_o <= 7'h00;
      supply_ram_data_o <= 8'h00;
    end else begin
      dsp_in_o          <= 16'h0000;
      dsp_in_o[crcs_pkg::BUSY_BIT_POS] <= supply_busy || sup_start;
      supply_ram_we_o   <= sup_done;
      supply_ram_addr_o <= crcs_pkg::SUPPLY_RAM_ADDR;
      supply_ram_data_o <= {2'h0, supply_result};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic frontend_q;
  // processor clock gate; wake events win over a stop command
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_en) begin
      dsp_clk_en_o <= 1'b0;
    end else if (gpio_wake_i || run_end_i || !frontend_q) begin
      dsp_clk_en_o <= 1'b1;
    end else if (dsp_stop_cmd_i) begin
      dsp_clk_en_o <= 1'b0;
    end
  end

  // delayed run bit: starting a run wakes the processor once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frontend_q <= 1'b0;
    end else begin
      frontend_q <= run_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program integrity monitor: walks sram against otp in idle time
  crcs_pkg::crcs_cmp_type cmp_state;
  crcs_pkg::crcs_cmp_type next_cmp_state;
  wire cmp_allowed = cmp_en && sram_sel && ring_osc_sel_i && run_en;
  wire cmp_go = cmp_allowed && dsp_idle_i;
  wire mismatch = pm_sram_data_i != pm_otp_data_i;
  wire addr_last = &pm_addr_o;

  // recovery states run to completion; compare pauses when not idle
  always_comb begin
    next_cmp_state = cmp_state;
    unique case (cmp_state)
      crcs_pkg::CMP_OFF:     if (cmp_go) next_cmp_state = crcs_pkg::CMP_RD;
      crcs_pkg::CMP_RD:      if (!cmp_allowed) next_cmp_state = crcs_pkg::CMP_OFF;
                             else if (cmp_go) next_cmp_state = crcs_pkg::CMP_CHK;
      crcs_pkg::CMP_CHK:     next_cmp_state = mismatch ? crcs_pkg::CMP_RESET
                                                       : crcs_pkg::CMP_RD;
      crcs_pkg::CMP_RESET:   next_cmp_state = crcs_pkg::CMP_COPY;
      crcs_pkg::CMP_COPY:    next_cmp_state = crcs_pkg::CMP_COPY_WR;
      crcs_pkg::CMP_COPY_WR: next_cmp_state = addr_last ? crcs_pkg::CMP_RESTART
                                                        : crcs_pkg::CMP_COPY;
      crcs_pkg::CMP_RESTART: next_cmp_state = crcs_pkg::CMP_OFF;
      default:               next_cmp_state = crcs_pkg::CMP_OFF;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_state <= crcs_pkg::CMP_OFF;
    end else begin
      cmp_state <= next_cmp_state;
    end
  end

  // address, strobes and sticky mismatch flag of the monitor
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pm_addr_o       <= '0;
      pm_sram_we_o    <= 1'b0;
      pm_sram_wdata_o <= 8'h00;
      por_o           <= 1'b0;
      dsp_restart_o   <= 1'b0;
      mismatch_seen   <= 1'b0;
    end else begin
      pm_sram_we_o  <= 1'b0;
      por_o         <= 1'b0;
      dsp_restart_o <= 1'b0;
      if (cmp_state == crcs_pkg::CMP_CHK) begin
        pm_addr_o <= mismatch ? '0 : pm_addr_o + PM_AW'(1);
        if (mismatch) begin
          por_o         <= 1'b1;
          mismatch_seen <= 1'b1;
        end
      end
      if (cmp_state == crcs_pkg::CMP_COPY) begin
        pm_sram_we_o    <= 1'b1;
        pm_sram_wdata_o <= pm_otp_data_i;
      end
      if (cmp_state == crcs_pkg::CMP_COPY_WR) begin
        pm_addr_o <= pm_addr_o + PM_AW'(1);
      end
      if (cmp_state == crcs_pkg::CMP_RESTART) begin
        dsp_restart_o <= 1'b1;
      end
    end
  end

  assign cmp_active = cmp_state != crcs_pkg::CMP_OFF;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_run_reset;
    @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !frontend_run_o && !dsp_clk_en_o;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("run set after reset");

  property p_run_write;
    @(posedge clk_i) disable iff (rst_i)
      (host_wr_i.en && host_wr_i.addr == crcs_pkg::RUN_CTRL_IDX)
        |=> frontend_run_o == $past(host_wr_i.data[0]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit not stored");

  property p_run_mirror;
    @(posedge clk_i) disable iff (rst_i)
      (host_rd_addr_i == crcs_pkg::STATUS_LOW_ADDR)
        |=> host_rd_data_o[0] == $past(frontend_run_o);
  endproperty
  a_run_mirror: assert property (p_run_mirror) else $error("run mirror wrong");

  property p_keep_awake;
    @(posedge clk_i) disable iff (rst_i)
      keep_awake |=> nvm_awake_o;
  endproperty
  a_keep_awake: assert property (p_keep_awake) else $error("nvm slept while kept awake");

  property p_trig_clear;
    @(posedge clk_i) disable iff (rst_i)
      (trig && !supply_busy && !trig_set) |=> !trig ##1 dsp_in_o[crcs_pkg::BUSY_BIT_POS];
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger did not self-clear");

  property p_result_write;
    @(posedge clk_i) disable iff (rst_i)
      sup_done |=> supply_ram_we_o && supply_ram_addr_o == 7'h5c &&
                   supply_ram_data_o == {2'h0, $past(supply_result)};
  endproperty
  a_result_write: assert property (p_result_write) else $error("supply result not placed");

  property p_cmp_gate;
    @(posedge clk_i) disable iff (rst_i)
      (cmp_state == crcs_pkg::CMP_OFF && !cmp_go) |=> cmp_state == crcs_pkg::CMP_OFF;
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare started while barred");

  property p_mismatch_por;
    @(posedge clk_i) disable iff (rst_i)
      (cmp_state == crcs_pkg::CMP_CHK && mismatch) |=> por_o ##2 pm_sram_we_o;
  endproperty
  a_mismatch_por: assert property (p_mismatch_por) else $error("mismatch without recovery");

  property p_stop_cmd;
    @(posedge clk_i) disable iff (rst_i)
      (dsp_stop_cmd_i && !gpio_wake_i && !run_end_i && frontend_q) |=> !dsp_clk_en_o;
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) else $error("clock not stopped");
endmodule
`default_nettype wire

// ===== crcs_host_model.sv
// host model: byte writes and reads on the register port
`default_nettype none
module crcs_host_model (
  input  wire logic                       clk_i,
  output var  crcs_pkg::crcs_host_wr_type wr_o,
  output var  logic [5:0]                 rd_addr_o,
  input  wire logic [7:0]                 rd_data_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port from time zero
  initial begin
    wr_o = '0;
    rd_addr_o = 6'h00;
  end
  ////////////////////////////////////////
  // one byte write, held for exactly one edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = {1'b1, a, d};
    @(negedge clk_i);
    wr_o = '0;
  endtask
  // answer is registered, so take it a cycle after the address
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_i);
    rd_addr_o = a;
    @(negedge clk_i);
    d = rd_data_i;
  endtask
  // run drops around every change so no half-written setup runs
  task automatic reconfig(input logic [6:0] a, input logic [7:0] d);
    wr(crcs_pkg::RUN_CTRL_IDX, 8'h00);
    wr(a, d);
    wr(crcs_pkg::RUN_CTRL_IDX, 8'hff);
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// self-checking bench of the config, run control and status bank
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                                  clk_i = 1'b0;
  logic                                  rst_i = 1'b1;
  crcs_pkg::crcs_host_wr_type            wr;
  crcs_pkg::crcs_res_wr_type             res = '0;
  logic [5:0]                            ra;
  logic [7:0]                            rdat;
  logic [crcs_pkg::WR_REG_COUNT-1:0][7:0] cfg;
  logic                                  run, dwe = 1'b0, sram_we, awake, clk_en;
  logic                                  osc = 1'b0, stop = 1'b0, gpio = 1'b0, idle = 1'b0;
  logic [15:0]                           dout = 16'h0000, din;
  logic [6:0]                            sram_addr;
  logic [7:0]                            sram_data, pm_d = 8'h00, d, otp = 8'h00;
  logic                                  acc = 1'b0, rend = 1'b0, por, pm_we;
  logic [5:0]                            sample = 6'h00;
  int                                    fail_count = 0, check_count = 0;
  // free-running bus clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  crcs_host_model host (.clk_i(clk_i), .wr_o(wr), .rd_addr_o(ra), .rd_data_i(rdat));
  crcs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .host_wr_i(wr), .host_rd_addr_i(ra),
    .host_rd_data_o(rdat), .res_wr_i(res), .cfg_o(cfg), .frontend_run_o(run),
    .dsp_out_we_i(dwe), .dsp_out_i(dout), .dsp_in_o(din), .supply_ram_we_o(sram_we),
    .supply_ram_addr_o(sram_addr), .supply_ram_data_o(sram_data),
    .low_freq_oscillator_i(osc), .ext_32k_i(1'b0), .supply_sample_i(sample), .rtc_gray_o(),
    .nvm_access_i(acc), .nvm_awake_o(awake), .dsp_stop_cmd_i(stop), .gpio_wake_i(gpio),
    .run_end_i(rend), .dsp_clk_en_o(clk_en), .dsp_idle_i(idle), .ring_osc_sel_i(idle),
    .pm_addr_o(), .pm_sram_data_i(pm_d), .pm_otp_data_i(otp), .pm_sram_we_o(pm_we),
    .pm_sram_wdata_o(), .por_o(por), .dsp_restart_o());
  ////////////////////////////////////////
  // one comparison, counted either way
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  // reset state, then setup through the run protocol
  task automatic t_config;
    logic [crcs_pkg::WR_REG_COUNT-1:0][7:0] c;
    chk(cfg === '0 && run === 1'b0, "reset state");
    host.rd(6'h18, d);
    chk(d[0] === 1'b0, "status run at reset");
    host.reconfig(crcs_pkg::NVM_AWAKE_IDX, 8'h01);
    repeat (2) @(negedge clk_i);
    chk(cfg[77] === 8'h01 && run === 1'b1, "run byte");
    chk(awake === 1'b1 && cfg[2] === 8'h01, "keep awake");
    chk(clk_en === 1'b1, "run start wakes processor");
    host.rd(6'h18, d);
    chk(d[0] === 1'b1, "status run mirror");
    c = cfg;
    host.wr(7'h4e, 8'h5a);
    @(negedge clk_i);
    chk(cfg === c, "write past last register");
    host.reconfig(crcs_pkg::NVM_AWAKE_IDX, 8'h00);
    repeat (2) @(negedge clk_i);
    chk(awake === 1'b0, "awake only per access");
    acc = 1'b1;
    @(negedge clk_i);
    acc = 1'b0;
    chk(awake === 1'b1, "awake during access");
    @(negedge clk_i);
    chk(awake === 1'b0, "asleep after access");
  endtask
  // supply check in fast or slow clock mode; osc is driven here only
  task automatic t_supply(input logic slow);
    int rises;
    int n;
    bit busy_seen;
    bit done;
    rises = 0;
    busy_seen = 0;
    done = 0;
    n = slow ? 272 : 17;
    host.reconfig(crcs_pkg::BG_TRIM_IDX, {3'b000, slow, 4'h7});
    sample = slow ? 6'h15 : 6'h2a;
    @(negedge clk_i);
    dwe = 1'b1;
    dout = 16'h4000;
    @(negedge clk_i);
    dwe = 1'b0;
    dout = 16'h0000;
    for (int i = 0; i < 1200 && !done; i++) begin
      @(negedge clk_i);
      if (din[8] === 1'b1) busy_seen = 1;
      if (sram_we === 1'b1) done = 1;
      else begin
        osc = ~osc;
        if (osc) rises++;
      end
    end
    if (!done) begin
      chk(1'b0, "supply check timeout");
      finish_test;
    end
    chk(busy_seen, "busy during conversion");
    chk(sram_addr === crcs_pkg::SUPPLY_RAM_ADDR, "result address");
    chk(sram_data === {2'b00, sample}, "result data");
    chk(rises >= n && rises <= n + 1, "conversion length");
    repeat (3) @(negedge clk_i);
    chk(din[8] === 1'b0, "trigger self-clears");
    host.rd(6'h19, d);
    chk(d === {2'b00, sample}, "status holds result");
  endtask
  // firmware result bytes, protected status and unmapped read
  task automatic t_results;
    @(negedge clk_i);
    res = {1'b1, 6'h03, 8'hc3};
    @(negedge clk_i);
    res = {1'b1, 6'h18, 8'hff};
    @(negedge clk_i);
    res = '0;
    host.rd(6'h03, d);
    chk(d === 8'hc3, "result byte");
    host.rd(6'h18, d);
    chk(d === 8'h03, "status not firmware written");
    host.rd(6'h2c, d);
    chk(d === 8'h00, "read past last byte");
  endtask
  // processor clock stops on command, port signal restarts it
  task automatic t_clkgate;
    @(negedge clk_i);
    stop = 1'b1;
    @(negedge clk_i);
    stop = 1'b0;
    @(negedge clk_i);
    chk(clk_en === 1'b0, "clock stop");
    gpio = 1'b1;
    @(negedge clk_i);
    gpio = 1'b0;
    @(negedge clk_i);
    chk(clk_en === 1'b1, "clock restart");
    stop = 1'b1;
    @(negedge clk_i);
    stop = 1'b0;
    rend = 1'b1;
    chk(clk_en === 1'b0, "clock stop before run end");
    @(negedge clk_i);
    rend = 1'b0;
    chk(clk_en === 1'b1, "run end restarts clock");
  endtask
  // integrity monitor: barred until sram mode, then a mismatch forces recovery
  task automatic t_monitor;
    bit hit;
    bit copied;
    hit = 0;
    copied = 0;
    idle = 1'b1;
    otp = 8'h01;
    host.reconfig(crcs_pkg::CMP_EN_IDX, 8'h80);
    repeat (4) @(negedge clk_i);
    host.rd(crcs_pkg::STATUS_LOW_ADDR, d);
    chk(d[3] === 1'b0, "compare ran without sram mode");
    host.reconfig(crcs_pkg::SRAM_SEL_IDX, 8'h01);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (por === 1'b1) hit = 1;
      if (pm_we === 1'b1 && hit) copied = 1;
    end
    chk(hit && copied, "mismatch without reset and recopy");
    host.rd(crcs_pkg::STATUS_HIGH_ADDR, d);
    chk(d === 8'h01, "mismatch flag in status");
    idle = 1'b0;
    host.reconfig(crcs_pkg::CMP_EN_IDX, 8'h00);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_config;
    t_supply(1'b0);
    t_supply(1'b1);
    t_results;
    t_clkgate;
    t_monitor;
    finish_test;
  end
endmodule
`default_nettype wire
